//--- flash_seq_defines.svh
// constants shared by both ends of the bulk factory programming link
`ifndef FLASH_SEQ_DEFINES_SVH
`define FLASH_SEQ_DEFINES_SVH

`define ADDR_W            23
`define DATA_W            16
`define BLK_LSB           16
`define BUF_WORDS         32
`define BUF_IDX_W         5
`define ERASED_WORD       16'hFFFF

// ****************************************
// command codes (arbitrary values)
// ****************************************
`define CMD_BULK_SETUP    16'h0080
`define CMD_BULK_CONFIRM  16'h00D0
`define CMD_READ_ARRAY    16'h00FF
`define CMD_READ_STATUS   16'h0070
`define CMD_READ_ID       16'h0090
`define CMD_QUERY         16'h0098
`define CMD_CLEAR_STATUS  16'h0050
`define CMD_SUSPEND       16'h00B0
`define CMD_RESUME        16'h00D0

// ****************************************
// status bit positions
// ****************************************
`define ST_READY          7
`define ST_PROG_ERR       4
`define ST_VOLT_ERR       3
`define ST_SUSP           2
`define ST_LOCK_ERR       1
`define ST_BUF_BUSY       0

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS     20
`define SETUP_CHECK_NS    2000
`define PROG_BUFFER_NS    4000
`define SETUP_CHECK_CYC   ((`SETUP_CHECK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROG_BUFFER_CYC   ((`PROG_BUFFER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- flash_seq_pkg.sv
// types shared by both ends of the bulk factory programming link
package flash_seq_pkg;

  typedef enum logic [1:0] {
    MODE_STATUS,
    MODE_ARRAY,
    MODE_INFO
  } read_mode_t;

  typedef enum logic [2:0] {
    D_IDLE,
    D_SETUP_CHECK,
    D_FILL,
    D_PROGRAM,
    D_SUSPENDED,
    D_EXIT
  } dev_state_t;

  typedef enum logic [2:0] {
    H_IDLE,
    H_SETUP,
    H_CONFIRM,
    H_POLL,
    H_WAIT,
    H_FILL,
    H_EXIT,
    H_DONE
  } host_state_t;

endpackage

//--- flash_bus_if.sv
// parallel memory bus between the programming host and the flash sequencer
`timescale 1ns/1ps
`include "flash_seq_defines.svh"

interface flash_bus_if;
  logic                 chip_sel_n;
  logic                 wr_stb;
  logic                 rd_stb;
  logic                 hw_reset_n;
  logic [`ADDR_W-1:0]   addr;
  logic [`DATA_W-1:0]   wdata;
  logic [`DATA_W-1:0]   rdata;
  logic                 rvalid;

  modport device (
    input  chip_sel_n,
    input  wr_stb,
    input  rd_stb,
    input  hw_reset_n,
    input  addr,
    input  wdata,
    output rdata,
    output rvalid
  );

  modport host (
    output chip_sel_n,
    output wr_stb,
    output rd_stb,
    output hw_reset_n,
    output addr,
    output wdata,
    input  rdata,
    input  rvalid
  );
endinterface

//--- bulk_factory_program_sequencer.sv
// flash-side command sequencer for bulk factory programming with program suspend
`timescale 1ns/1ps
`include "flash_seq_defines.svh"

// Contract
// R01: confirm accepted clears ready, state machine busy
// R02: setup error sets program, lock, voltage errors
// R03: reads return status; read-status write is data
// R04: host checks ready and buffer busy after setup
// R05: fixed 32-word loads from buffer offset zero
// R06: program only full buffer; host pads ones
// R07: foreign block address mid-fill exits, discards
// R08: unaligned start address aborts with program error
// R09: host first-word address low five bits zero
// R10: host holds first-word address until exit
// R11: buffers go to consecutive array locations
// R12: internal address wraps within the block
// R13: buffer busy clears when data reaches array
// R14: stray writes ignored while programming
// R15: all-ones write to other block exits
// R16: exit sets ready, keeps read mode
// R17: one block per run, not suspendable
// R18: host unlocks block before setup; bulk_program_host sends no unlock and leaves it to the caller
// R19: suspend halts, status reads, ready and suspended
// R20: suspended accepts only reads, query, resume
// R21: program under erase suspend is suspendable
// R22: chip select standby, hardware reset resets
// R23: resume restarts and clears ready, suspended
// R24: setup and program times are parameters
module bulk_factory_program_sequencer
  import flash_seq_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst,
  flash_bus_if.device              bus,
  input  wire logic                block_locked,
  input  wire logic                vpp_ok,
  input  wire logic                erase_suspended,
  input  wire logic [`DATA_W-1:0]  array_rdata,
  output logic                     array_we,
  output logic [`ADDR_W-1:0]       array_addr,
  output logic [`DATA_W-1:0]       array_wdata,
  output logic [7:0]               status,
  output logic                     standby
);

  localparam logic [7:0] SETUP_CYC = 8'(`SETUP_CHECK_CYC);
  localparam logic [7:0] PROG_CYC  = 8'(`PROG_BUFFER_CYC);

  // ****************************************
  // state
  // ****************************************
  dev_state_t              state_reg;
  read_mode_t              mode_reg;
  read_mode_t              saved_mode_reg;
  logic                    setup_pend_reg;
  logic                    first_reg;
  logic [7:0]              cnt_reg;
  logic [`BUF_IDX_W-1:0]   idx_reg;
  logic [`ADDR_W-1:0]      blk_addr_reg;
  logic [`ADDR_W-1:0]      wr_addr_reg;
  logic                    ready_reg;
  logic                    busy_reg;
  logic                    susp_reg;
  logic                    perr_reg;
  logic                    verr_reg;
  logic                    lerr_reg;
  logic [`DATA_W-1:0]      buf_mem [`BUF_WORDS];
  logic [`DATA_W-1:0]      rdata_reg;
  logic                    rvalid_reg;

  // ****************************************
  // decode
  // ****************************************
  function automatic logic [`ADDR_W-1:0] next_addr(input logic [`ADDR_W-1:0] a);
    // the in-block offset rolls over, the block bits stay put
    next_addr = {a[`ADDR_W-1:`BLK_LSB], a[`BLK_LSB-1:0] + 1'b1}; // see R12
  endfunction

  wire dev_rst    = rst | ~bus.hw_reset_n; // see R22
  wire wr         = bus.wr_stb & ~bus.chip_sel_n;
  wire rd         = bus.rd_stb & ~bus.chip_sel_n;
  wire cmd_setup  = bus.wdata == `CMD_BULK_SETUP;
  wire cmd_conf   = bus.wdata == `CMD_BULK_CONFIRM;
  wire cmd_rarray = bus.wdata == `CMD_READ_ARRAY;
  wire cmd_rstat  = bus.wdata == `CMD_READ_STATUS;
  wire cmd_info   = (bus.wdata == `CMD_READ_ID) | (bus.wdata == `CMD_QUERY);
  wire cmd_clear  = bus.wdata == `CMD_CLEAR_STATUS;
  wire cmd_susp   = bus.wdata == `CMD_SUSPEND;
  wire cmd_resume = bus.wdata == `CMD_RESUME;
  wire same_blk   = bus.addr[`ADDR_W-1:`BLK_LSB] == blk_addr_reg[`ADDR_W-1:`BLK_LSB];
  wire aligned    = bus.addr[`BUF_IDX_W-1:0] == '0;
  wire setup_bad  = block_locked | ~vpp_ok;
  wire fill_last  = idx_reg == 5'(`BUF_WORDS - 1);
  wire prog_word  = cnt_reg < 8'(`BUF_WORDS);
  wire prog_end   = cnt_reg == PROG_CYC - 8'h01;
  wire susp_ok    = erase_suspended; // see R17 see R21
  wire [7:0] status_w;

  assign status_w = {ready_reg, 2'b00, perr_reg, verr_reg, susp_reg, lerr_reg, busy_reg};

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge clk) begin
    array_we <= 1'b0;
    if (dev_rst) begin
      state_reg      <= D_IDLE;
      mode_reg       <= MODE_ARRAY;
      saved_mode_reg <= MODE_ARRAY;
      setup_pend_reg <= 1'b0;
      first_reg      <= 1'b0;
      cnt_reg        <= 8'h00;
      idx_reg        <= '0;
      blk_addr_reg   <= '0;
      wr_addr_reg    <= '0;
      ready_reg      <= 1'b1;
      busy_reg       <= 1'b0;
      susp_reg       <= 1'b0;
      perr_reg       <= 1'b0;
      verr_reg       <= 1'b0;
      lerr_reg       <= 1'b0;
      array_addr     <= '0;
      array_wdata    <= '0;
    end else begin
      unique case (state_reg)
        D_IDLE: begin
          if (wr) begin
            setup_pend_reg <= cmd_setup;
            if (setup_pend_reg && cmd_conf) begin
              ready_reg      <= 1'b0; // see R01
              busy_reg       <= 1'b1;
              saved_mode_reg <= mode_reg;
              mode_reg       <= MODE_STATUS; // see R03
              blk_addr_reg   <= bus.addr;
              cnt_reg        <= SETUP_CYC - 8'h01; // see R24
              state_reg      <= D_SETUP_CHECK;
            end else if (cmd_rarray) begin
              mode_reg <= MODE_ARRAY;
            end else if (cmd_rstat || cmd_setup) begin
              mode_reg <= MODE_STATUS;
            end else if (cmd_info) begin
              mode_reg <= MODE_INFO;
            end else if (cmd_clear) begin
              perr_reg <= 1'b0;
              verr_reg <= 1'b0;
              lerr_reg <= 1'b0;
            end
          end
        end
        D_SETUP_CHECK: begin
          cnt_reg <= cnt_reg - 8'h01;
          if (cnt_reg == 8'h00) begin
            busy_reg <= 1'b0; // see R04
            if (setup_bad) begin
              perr_reg  <= 1'b1; // see R02
              lerr_reg  <= block_locked;
              verr_reg  <= ~vpp_ok;
              ready_reg <= 1'b1;
              state_reg <= D_IDLE;
            end else begin
              first_reg <= 1'b1;
              idx_reg   <= '0; // see R05
              state_reg <= D_FILL;
            end
          end
        end
        D_FILL: begin
          if (wr) begin
            if (!same_blk) begin
              state_reg <= D_EXIT; // see R07 see R15
            end else if (first_reg && !aligned) begin
              perr_reg  <= 1'b1; // see R08
              ready_reg <= 1'b1;
              state_reg <= D_IDLE;
            end else begin
              buf_mem[idx_reg] <= bus.wdata; // see R03 see R05
              idx_reg          <= idx_reg + 1'b1;
              first_reg        <= 1'b0;
              if (first_reg) begin
                wr_addr_reg <= bus.addr;
              end
              if (fill_last) begin
                busy_reg  <= 1'b1; // see R06 see R13
                cnt_reg   <= 8'h00;
                state_reg <= D_PROGRAM;
              end
            end
          end
        end
        D_PROGRAM: begin
          // other writes are dropped here
          if (wr && cmd_susp && susp_ok) begin // see R14 see R17
            ready_reg <= 1'b1; // see R19
            susp_reg  <= 1'b1;
            state_reg <= D_SUSPENDED;
          end else begin
            cnt_reg <= cnt_reg + 8'h01;
            if (prog_word) begin
              array_we    <= 1'b1;
              array_addr  <= wr_addr_reg; // see R11
              array_wdata <= buf_mem[cnt_reg[`BUF_IDX_W-1:0]];
              wr_addr_reg <= next_addr(wr_addr_reg); // see R12
            end
            if (prog_end) begin
              busy_reg  <= 1'b0; // see R13
              idx_reg   <= '0;
              state_reg <= D_FILL;
            end
          end
        end
        D_SUSPENDED: begin
          if (wr) begin
            if (cmd_resume) begin
              ready_reg <= 1'b0; // see R23
              susp_reg  <= 1'b0;
              mode_reg  <= MODE_STATUS;
              state_reg <= D_PROGRAM;
            end else if (cmd_rarray) begin
              mode_reg <= MODE_ARRAY; // see R20
            end else if (cmd_rstat) begin
              mode_reg <= MODE_STATUS;
            end else if (cmd_info) begin
              mode_reg <= MODE_INFO;
            end
          end
        end
        D_EXIT: begin
          ready_reg <= 1'b1; // see R16
          busy_reg  <= 1'b0;
          mode_reg  <= saved_mode_reg;
          state_reg <= D_IDLE;
        end
        default: begin
          state_reg <= D_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // read port
  // ****************************************
  wire [`DATA_W-1:0] rd_mux = (mode_reg == MODE_ARRAY)  ? array_rdata :
                              (mode_reg == MODE_STATUS) ? {8'h00, status_w} : '0;

  always_ff @(posedge clk) begin
    if (dev_rst) begin
      rdata_reg  <= '0;
      rvalid_reg <= 1'b0;
      status     <= 8'h80;
      standby    <= 1'b0;
    end else begin
      rvalid_reg <= rd;
      if (rd) begin
        rdata_reg <= rd_mux;
      end
      status  <= status_w;
      standby <= bus.chip_sel_n; // see R22
    end
  end

  assign bus.rdata  = rdata_reg;
  assign bus.rvalid = rvalid_reg;

endmodule

//--- bulk_program_host.sv
// host programming engine that streams one block through the bulk factory algorithm
`timescale 1ns/1ps
`include "flash_seq_defines.svh"

module bulk_program_host
  import flash_seq_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst,
  flash_bus_if.host                bus,
  input  wire logic                start,
  input  wire logic [`ADDR_W-1:0]  start_addr,
  input  wire logic [`DATA_W-1:0]  word_data,
  input  wire logic                word_last,
  input  wire logic                word_valid,
  output logic                     word_ready,
  output logic                     busy,
  output logic                     done,
  output logic [7:0]               final_status
);

  // ****************************************
  // two-entry word buffer
  // ****************************************
  logic [`DATA_W:0]  fifo_mem [2];
  logic              wptr_reg;
  logic              rptr_reg;
  logic [1:0]        fcnt_reg;

  host_state_t             state_reg;
  logic [`ADDR_W-1:0]      base_reg;
  logic [`BUF_IDX_W-1:0]   idx_reg;
  logic                    pad_reg;
  logic                    more_reg;
  logic                    exiting_reg;

  wire        fifo_ne  = fcnt_reg != 2'h0;
  wire [`DATA_W:0] head = fifo_mem[rptr_reg];
  wire        push     = word_valid & word_ready;
  wire        fill_go  = (state_reg == H_FILL) & (pad_reg | fifo_ne);
  wire        pop      = fill_go & ~pad_reg;
  wire [1:0]  fcnt_next = 2'(fcnt_reg + {1'b0, push} - {1'b0, pop});
  wire [7:0]  st       = bus.rdata[7:0];
  wire        st_ready = st[`ST_READY];
  wire        st_busy  = st[`ST_BUF_BUSY];

  always_ff @(posedge clk) begin
    if (rst) begin
      wptr_reg   <= 1'b0;
      rptr_reg   <= 1'b0;
      fcnt_reg   <= 2'h0;
      word_ready <= 1'b0;
    end else begin
      if (push) begin
        fifo_mem[wptr_reg] <= {word_last, word_data};
        wptr_reg           <= ~wptr_reg;
      end
      if (pop) begin
        rptr_reg <= ~rptr_reg;
      end
      fcnt_reg   <= fcnt_next;
      word_ready <= fcnt_next != 2'h2;
    end
  end

  // ****************************************
  // programming sequence
  // ****************************************
  always_ff @(posedge clk) begin
    bus.wr_stb <= 1'b0;
    bus.rd_stb <= 1'b0;
    done       <= 1'b0;
    if (rst) begin
      state_reg      <= H_IDLE;
      base_reg       <= '0;
      idx_reg        <= '0;
      pad_reg        <= 1'b0;
      more_reg       <= 1'b0;
      exiting_reg    <= 1'b0;
      busy           <= 1'b0;
      final_status   <= 8'h00;
      bus.chip_sel_n <= 1'b1;
      bus.hw_reset_n <= 1'b1;
      bus.addr       <= '0;
      bus.wdata      <= '0;
    end else begin
      unique case (state_reg)
        H_IDLE: begin
          if (start) begin
            // block assumed unlocked by the caller; see R18
            base_reg       <= {start_addr[`ADDR_W-1:`BUF_IDX_W], 5'h00}; // see R09
            busy           <= 1'b1;
            pad_reg        <= 1'b0;
            more_reg       <= 1'b1;
            exiting_reg    <= 1'b0;
            bus.chip_sel_n <= 1'b0;
            state_reg      <= H_SETUP;
          end
        end
        H_SETUP: begin
          bus.wr_stb <= 1'b1;
          bus.addr   <= base_reg;
          bus.wdata  <= `CMD_BULK_SETUP;
          state_reg  <= H_CONFIRM;
        end
        H_CONFIRM: begin
          bus.wr_stb <= 1'b1;
          bus.wdata  <= `CMD_BULK_CONFIRM;
          state_reg  <= H_POLL;
        end
        H_POLL: begin
          // plain reads give status; no read-status command; see R03
          bus.rd_stb <= 1'b1;
          state_reg  <= H_WAIT;
        end
        H_WAIT: begin
          if (bus.rvalid) begin
            if (st_ready) begin // see R04 see R16
              final_status <= st;
              state_reg    <= H_DONE;
            end else if (st_busy || exiting_reg) begin
              state_reg <= H_POLL; // see R13 see R14
            end else if (more_reg) begin
              idx_reg   <= '0;
              state_reg <= H_FILL;
            end else begin
              state_reg <= H_EXIT;
            end
          end
        end
        H_FILL: begin
          if (fill_go) begin
            bus.wr_stb <= 1'b1;
            bus.addr   <= base_reg; // see R10
            bus.wdata  <= pad_reg ? `ERASED_WORD : head[`DATA_W-1:0]; // see R06
            if (!pad_reg && head[`DATA_W]) begin
              pad_reg  <= 1'b1;
              more_reg <= 1'b0;
            end
            idx_reg <= idx_reg + 1'b1;
            if (idx_reg == 5'(`BUF_WORDS - 1)) begin
              state_reg <= H_POLL;
            end
          end
        end
        H_EXIT: begin
          bus.wr_stb  <= 1'b1;
          bus.addr    <= base_reg ^ (`ADDR_W'(1) << `BLK_LSB);
          bus.wdata   <= `ERASED_WORD; // see R15
          exiting_reg <= 1'b1;
          state_reg   <= H_POLL;
        end
        H_DONE: begin
          done           <= 1'b1;
          busy           <= 1'b0;
          bus.chip_sel_n <= 1'b1;
          state_reg      <= H_IDLE;
        end
      endcase
    end
  end

endmodule

//--- flash_link_props.sv
// concurrent checks on the bus joining the programming host and the flash sequencer
`timescale 1ns/1ps
`include "flash_seq_defines.svh"

module flash_link_props (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               chip_sel_n,
  input wire logic               wr_stb,
  input wire logic               rd_stb,
  input wire logic               hw_reset_n,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [`DATA_W-1:0] wdata,
  input wire logic [`DATA_W-1:0] rdata,
  input wire logic               rvalid
);
  // ****************************************
  // run tracking
  // ****************************************
  logic               in_run_reg;
  logic               in_run_next;
  logic               setup_seen_reg;
  logic [`ADDR_W-1:0] run_addr_reg;
  logic [4:0]         fill_cnt_reg;
  logic [4:0]         fill_cnt_next;
  wire logic          wr_sel;
  wire logic          rd_sel;
  wire logic          setup_wr;
  wire logic          confirm_wr;
  wire logic          own_blk;
  wire logic          data_wr;
  wire logic          exit_wr;
  wire logic          fill_end;

  assign wr_sel        = wr_stb && !chip_sel_n;
  assign rd_sel        = rd_stb && !chip_sel_n;
  assign setup_wr      = wr_sel && wdata == `CMD_BULK_SETUP;
  assign confirm_wr    = wr_sel && setup_seen_reg && wdata == `CMD_BULK_CONFIRM;
  assign own_blk       = addr[`ADDR_W-1:`BLK_LSB] == run_addr_reg[`ADDR_W-1:`BLK_LSB];
  assign data_wr       = wr_sel && in_run_reg && own_blk;
  assign exit_wr       = wr_sel && in_run_reg && !own_blk;
  assign fill_end      = data_wr && fill_cnt_reg == 5'h1F;
  assign in_run_next   = confirm_wr ? 1'h1 : (setup_wr || exit_wr) ? 1'h0 : in_run_reg;
  assign fill_cnt_next = confirm_wr ? 5'h00 : data_wr ? fill_cnt_reg + 5'h01 : fill_cnt_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      in_run_reg     <= 1'h0;
      setup_seen_reg <= 1'h0;
      run_addr_reg   <= '0;
      fill_cnt_reg   <= 5'h00;
    end else begin
      in_run_reg     <= in_run_next;
      setup_seen_reg <= setup_wr;
      run_addr_reg   <= confirm_wr ? addr : run_addr_reg;
      fill_cnt_reg   <= fill_cnt_next;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_setup;
    setup_wr;
  endsequence
  sequence s_confirm;
    wr_sel && wdata == `CMD_BULK_CONFIRM && addr == $past(addr);
  endsequence

  a_setup_then_confirm: assert property (s_setup |=> s_confirm)
    else $error("setup not followed by confirm at the same address");
  a_start_aligned: assert property (confirm_wr |-> addr[4:0] == 5'h00)
    else $error("first word address not on a buffer boundary");
  a_busy_after_confirm: assert property (confirm_wr |-> ##[2:4] (rvalid && !rdata[`ST_READY]))
    else $error("ready not cleared after confirm");
  a_addr_held: assert property (data_wr |-> addr == run_addr_reg)
    else $error("first word address changed during streaming");
  a_exit_ones: assert property (exit_wr |-> wdata == `ERASED_WORD)
    else $error("exit write data not all ones");
  a_fill_quiet: assert property (fill_end |=> (!wr_sel)[*4])
    else $error("write issued right after a buffer fill");
  a_read_answer: assert property (rd_sel |=> rvalid)
    else $error("read not answered in one cycle");
  a_rvalid_cause: assert property (rvalid |-> $past(rd_sel))
    else $error("read answer without a read");
  a_reset_idle: assert property (hw_reset_n)
    else $error("hardware reset driven during normal run");
  a_busy_after_fill: assert property (fill_end |-> ##[2:4] (rvalid && rdata[`ST_BUF_BUSY]))
    else $error("buffer busy not shown after a full buffer");
  a_ready_on_exit: assert property (exit_wr |-> ##[4:8] (rvalid && rdata[`ST_READY]))
    else $error("ready not set after exit write");
endmodule

//--- testbench.sv
// self-checking bench joining the programming host and the flash sequencer
`timescale 1ns/1ps
`include "flash_seq_defines.svh"

module testbench
  import flash_seq_pkg::*;
;
  logic               clk;
  logic               rst;
  logic               start;
  logic [`ADDR_W-1:0] start_addr;
  logic [`DATA_W-1:0] word_data;
  logic               word_last;
  logic               word_valid;
  logic               word_ready;
  logic               busy;
  logic               done;
  logic [7:0]         final_status;
  logic               block_locked;
  logic               vpp_ok;
  logic               erase_suspended;
  logic               array_we;
  logic [`ADDR_W-1:0] array_addr;
  logic [`DATA_W-1:0] array_wdata;
  logic [7:0]         status;
  logic               standby;
  int                 failures;
  int                 num_checks;
  int                 cycles;
  logic [`ADDR_W-1:0] addr_q[$];
  logic [`DATA_W-1:0] data_q[$];

  flash_bus_if flash_bus_if_i ();

  bulk_program_host bulk_program_host_i (.clk(clk), .rst(rst), .bus(flash_bus_if_i),
    .start(start), .start_addr(start_addr), .word_data(word_data), .word_last(word_last),
    .word_valid(word_valid), .word_ready(word_ready), .busy(busy), .done(done),
    .final_status(final_status));

  bulk_factory_program_sequencer bulk_factory_program_sequencer_i (.clk(clk), .rst(rst),
    .bus(flash_bus_if_i), .block_locked(block_locked), .vpp_ok(vpp_ok),
    .erase_suspended(erase_suspended), .array_rdata(16'h0000), .array_we(array_we),
    .array_addr(array_addr), .array_wdata(array_wdata), .status(status), .standby(standby));

  flash_link_props flash_link_props_i (.clk(clk), .rst(rst),
    .chip_sel_n(flash_bus_if_i.chip_sel_n), .wr_stb(flash_bus_if_i.wr_stb),
    .rd_stb(flash_bus_if_i.rd_stb), .hw_reset_n(flash_bus_if_i.hw_reset_n),
    .addr(flash_bus_if_i.addr), .wdata(flash_bus_if_i.wdata),
    .rdata(flash_bus_if_i.rdata), .rvalid(flash_bus_if_i.rvalid));

  always #10 clk = ~clk;

  // array write monitor and hang guard
  always @(posedge clk) begin
    if (array_we === 1'h1) begin
      addr_q.push_back(array_addr);
      data_q.push_back(array_wdata);
    end
    cycles++;
    if (cycles == 40000) begin
      failures++;
      $display("[ERR] timeout expected finish seen hang");
      complete_run();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic reset_dut();
    @(posedge clk);
    #1 rst = 1'h1;
    repeat (2) @(posedge clk);
    #1 rst = 1'h0;
    addr_q.delete();
    data_q.delete();
  endtask

  // streams n words with gaps, then waits for the run to end
  task automatic run_block(input logic [`ADDR_W-1:0] a, input int n);
    int i;
    int cyc;
    i = 0;
    cyc = 0;
    @(posedge clk);
    #1 start_addr = a;
    start = 1'h1;
    @(posedge clk);
    #1 start = 1'h0;
    while (done !== 1'h1 && cyc < 20000) begin
      word_valid = (i < n) && (cyc % 3 != 2);
      word_data = 16'h1000 + i[15:0];
      word_last = (i == n - 1);
      @(posedge clk);
      if (word_valid && word_ready === 1'h1) i++;
      #1 cyc++;
    end
    word_valid = 1'h0;
    check("done", done, 1'h1);
    @(posedge clk);
    #1 check("busy", busy, 1'h0);
  endtask

  task automatic t_reset_values();
    reset_dut();
    check("status", status, 8'h80);
    @(posedge clk);
    #1 check("standby", standby, 1'h1);
    $display("test reset_values done");
  endtask

  task automatic t_stream(input string name, input logic [`ADDR_W-1:0] a, input int n);
    int cnt;
    reset_dut();
    run_block(a, n);
    cnt = ((n + 31) / 32) * 32;
    check("write_count", addr_q.size(), cnt);
    for (int k = 0; k < cnt && k < addr_q.size(); k++) begin
      check("array_addr", addr_q[k], {a[22:16], a[15:0] + k[15:0]});
      check("array_data", data_q[k], k < n ? 16'h1000 + k[15:0] : `ERASED_WORD);
    end
    check("final_status", final_status, 8'h80);
    check("status", status, 8'h80);
    check("standby", standby, 1'h1);
    $display("test %s done", name);
  endtask

  task automatic t_setup_err(input logic locked, input logic vok, input logic [7:0] exp);
    reset_dut();
    block_locked = locked;
    vpp_ok = vok;
    run_block(23'h000000, 32);
    check("final_status", final_status, exp);
    check("write_count", addr_q.size(), 0);
    block_locked = 1'h0;
    vpp_ok = 1'h1;
    $display("test setup_err %0d %0d done", locked, vok);
  endtask

  initial begin
    clk = 1'h0;
    rst = 1'h1;
    start = 1'h0;
    start_addr = '0;
    word_data = '0;
    word_last = 1'h0;
    word_valid = 1'h0;
    block_locked = 1'h0;
    vpp_ok = 1'h1;
    erase_suspended = 1'h0;
    failures = 0;
    num_checks = 0;
    cycles = 0;
    t_reset_values();
    t_stream("padded", 23'h000040, 40);
    t_stream("wrap", 23'h01FFE0, 64);
    erase_suspended = 1'h1;
    t_stream("exact", 23'h020000, 32);
    erase_suspended = 1'h0;
    t_setup_err(1'h1, 1'h1, 8'h92);
    t_setup_err(1'h0, 1'h0, 8'h98);
    t_setup_err(1'h1, 1'h0, 8'h9A);
    complete_run();
  end
endmodule
